// ---- hw/vie_defs.svh ----
// Purpose: offsets, field positions, reset values and codes of the exit/inject unit
// Assumes: 32-bit classic wishbone, byte addresses on wb_adr_i
// Notes: definitions only
`ifndef VIE_DEFS_SVH
`define VIE_DEFS_SVH
`define VIE_OFS_CTRL 8'h00
`define VIE_OFS_GUEST 8'h04
`define VIE_OFS_ENTRY 8'h08
`define VIE_OFS_GIP 8'h0c
`define VIE_OFS_HOST 8'h10
`define VIE_OFS_MSI 8'h14
`define VIE_OFS_CMD 8'h18
`define VIE_OFS_REASON 8'h1c
`define VIE_OFS_XINFO 8'h20
`define VIE_OFS_STATE 8'h24
`define VIE_OFS_ISTAT 8'h28
`define VIE_OFS_IMASK 8'h2c
// control bits
`define VIE_CTRL_EXT 0
`define VIE_CTRL_ACK 1
`define VIE_CTRL_WIN 2
`define VIE_CTRL_MCE 3
// guest interruptibility bits
`define VIE_G_IF 0
`define VIE_G_STI 1
`define VIE_G_MOVSS 2
// entry / exit information layout
`define VIE_INFO_VALID 31
`define VIE_TYPE_HI 10
`define VIE_TYPE_LO 8
`define VIE_TYPE_EXT 3'h0
// command bits
`define VIE_CMD_RESUME 0
`define VIE_CMD_ENTER 1
`define VIE_CMD_LEAVE 2
`define VIE_CMD_SETIF 3
`define VIE_CMD_MSI 4
// message layout
`define VIE_MSI_DEST_POS 16
`define VIE_MSI_DMODE_POS 8
`define VIE_MSI_TRIG_POS 15
`define VIE_MSI_ADDR_BASE 32'h00f0_0000
// exit reasons and abort codes
`define VIE_RSN_EXT 16'h0001
`define VIE_RSN_WIN 16'h0007
`define VIE_RSN_FAIL 16'h0021
`define VIE_AB_NONE 3'h0
`define VIE_AB_STORE 3'h1
`define VIE_AB_PAGE_DIRECTORY_POINTER 3'h2
`define VIE_AB_CORRUPT 3'h3
`define VIE_AB_LOAD 3'h4
`define VIE_AB_MC 3'h5
`define VIE_AB_HOST 3'h6
// reset values
`define VIE_RST_WORD 32'h0000_0000
`define VIE_RST_HOST 32'h0000_0001
`endif

// ---- hw/vie_pkg.sv ----
// Purpose: shared types of the exit/inject unit
// Assumes: nothing
// Notes: numbers live in vie_defs.svh
package vie_pkg;
    typedef logic [7:0] vie_vec_t;
    typedef logic [31:0] vie_word_t;
    typedef enum logic [2:0] {
        S_OFF, S_ROOT, S_GUEST, S_ACK, S_EXIT, S_ABORT, S_SHUT
    } vie_state_t;
endpackage : vie_pkg

// ---- hw/vie_msi_if.sv ----
// Purpose: carries message fields to the formatter and the built words back
// Assumes: one clock domain
// Notes: purely combinational path
`timescale 1ns/1ns
interface vie_msi_if;
    logic [7:0] dest;
    logic [7:0] vector;
    logic [2:0] dmode;
    logic trig;
    logic [31:0] addr;
    logic [31:0] data;
    modport fmt (input dest, input vector, input dmode, input trig, output addr, output data);
    modport core (output dest, output vector, output dmode, output trig, input addr, input data);
endinterface : vie_msi_if

// ---- hw/vie_sync3.sv ----
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: d is asynchronous to ref_clk
// Notes: q follows once stages two and three agree
`timescale 1ns/1ns
module vie_sync3 #(
    parameter int W = 1
) (
    input wire logic ref_clk, // core clock
    input wire logic nrst, // async reset, low
    input wire logic [W-1:0] d, // raw pins
    output logic [W-1:0] q // filtered level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule : vie_sync3

// ---- hw/vie_msi_fmt.sv ----
// Purpose: builds the address and data words of a signalled-message interrupt
// Assumes: fields are stable while a message is pending
// Notes: destination goes in the address, vector and modes in the data
`timescale 1ns/1ns
`include "vie_defs.svh"
module vie_msi_fmt (
    vie_msi_if.fmt m // fields in, words out
);
    import vie_pkg::*;
    assign m.addr = `VIE_MSI_ADDR_BASE | (32'(m.dest) << `VIE_MSI_DEST_POS);
    assign m.data = (32'(m.trig) << `VIE_MSI_TRIG_POS)
        | (32'(m.dmode) << `VIE_MSI_DMODE_POS) | 32'(m.vector);
endmodule : vie_msi_fmt

// ---- hw/vie_core.sv ----
// Purpose: guest exit on interrupts, acknowledge on exit, event injection, abort and
//   machine-check handling, reached over classic wishbone
// Assumes: fault inputs come from same-clock logic; ext_irq and mc_pin are asynchronous
// Notes: abort and shutdown hold until reset
// How it works
// - With external exiting set, an arriving interrupt makes the guest exit.
// - Every exit clears the host interrupt enable flag.
// - An exit from an external interrupt records exit reason one.
// - With acknowledge on exit, the interrupt is acknowledged and its vector stored.
// - Guest is ready only with its flag set and both blockings clear.
// - With window exiting set, the guest exits once it becomes interruptible.
// - At most one event is injected per entry; delivery clears the entry valid bit.
// - An injected external interrupt fetches the gate and pushes flags and pointer.
// - Injecting an external interrupt into a non-ready guest fails the entry with a failure reason.
// - Each exit loads host state and checks it for consistency.
// - Store, pointer, load, corruption or machine-check failures during exit abort.
// - Machine check in enter or leave raises the exception, or shuts down.
// - A message write carries destination in address, vector and modes in data.
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "vie_defs.svh"
module vie_core (
    input wire logic ref_clk, // 10 MHz core clock
    input wire logic nrst, // async reset, low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire vie_pkg::vie_word_t wb_dat_i, // write data
    output vie_pkg::vie_word_t wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic ext_irq, // external interrupt pin
    input wire logic mc_pin, // machine check pin
    input wire logic msr_store_fail, // guest register store failed
    input wire logic page_directory_pointer_fail, // page directory pointer load failed
    input wire logic virtual_machine_control_structure_corrupt, // control structure corrupted
    input wire logic msr_load_fail, // host register load failed
    input wire logic vec_valid, // controller returns vector
    input wire vie_pkg::vie_vec_t host_vec, // host vector
    output logic int_ack, // acknowledge pulse to controller
    output logic host_if, // host interrupt enable flag
    output logic deliver_valid, // injection pulse
    output vie_pkg::vie_vec_t deliver_vector, // gate vector
    output vie_pkg::vie_word_t deliver_flags, // flags to push
    output vie_pkg::vie_word_t deliver_ip, // pointer to push
    output logic mce_exc, // machine-check exception pulse
    output logic shutdown, // shutdown state
    output logic vmx_abort, // abort state
    output logic irq, // interrupt to host
    output logic msi_valid, // message pending
    input wire logic msi_ready, // message taken
    output vie_pkg::vie_word_t msi_addr, // message address
    output vie_pkg::vie_word_t msi_data // message data
);
    import vie_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    vie_state_t st_reg;
    vie_state_t st_next;
    vie_word_t ctrl_reg;
    vie_word_t guest_reg;
    vie_word_t entry_reg;
    vie_word_t gip_reg;
    vie_word_t host_reg;
    vie_word_t msi_cfg_reg;
    logic [15:0] reason_reg;
    vie_word_t xinfo_reg;
    logic [2:0] abcode_reg;
    logic [4:0] istat_reg;
    logic [4:0] imask_reg;
    logic ack_reg;
    logic [1:0] sync_q;
    logic irq_s;
    logic mc_s;
    vie_word_t wmask;
    vie_word_t rdata;
    logic wr_en;
    logic cmd_resume;
    logic cmd_enter;
    logic cmd_leave;
    logic cmd_setif;
    logic cmd_msi;
    logic guest_ready;
    logic exit_irq;
    logic exit_win;
    logic leave_guest;
    logic inj;
    logic inj_ext;
    logic ev_fail;
    logic ev_deliver;
    logic ev_exit;
    logic ev_abort;
    logic ev_mce;
    logic ev_shut;
    logic host_bad;
    logic fault;
    logic [2:0] fault_code;
    logic [4:0] ev_set;

    vie_sync3 #(.W(2)) u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .d({mc_pin, ext_irq}),
        .q(sync_q)
    );
    assign irq_s = sync_q[0];
    assign mc_s = sync_q[1];

    vie_msi_if msi_bus ();
    vie_msi_fmt u_fmt (
        .m(msi_bus.fmt)
    );
    assign msi_bus.vector = msi_cfg_reg[7:0];
    assign msi_bus.dmode = msi_cfg_reg[10:8];
    assign msi_bus.trig = msi_cfg_reg[15];
    assign msi_bus.dest = msi_cfg_reg[23:16];

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after the strobe, writes land on the ack edge
    assign wb_ack_o = ack_reg;
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic vie_word_t merge(input vie_word_t old, input vie_word_t nw,
                                        input vie_word_t m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = {a[7:2], 2'b00} == ofs;
    endfunction : hit

    assign cmd_resume = wr_en && hit(wb_adr_i, `VIE_OFS_CMD) && wb_sel_i[0]
        && wb_dat_i[`VIE_CMD_RESUME];
    assign cmd_enter = wr_en && hit(wb_adr_i, `VIE_OFS_CMD) && wb_sel_i[0]
        && wb_dat_i[`VIE_CMD_ENTER];
    assign cmd_leave = wr_en && hit(wb_adr_i, `VIE_OFS_CMD) && wb_sel_i[0]
        && wb_dat_i[`VIE_CMD_LEAVE];
    assign cmd_setif = wr_en && hit(wb_adr_i, `VIE_OFS_CMD) && wb_sel_i[0]
        && wb_dat_i[`VIE_CMD_SETIF];
    assign cmd_msi = wr_en && hit(wb_adr_i, `VIE_OFS_CMD) && wb_sel_i[0]
        && wb_dat_i[`VIE_CMD_MSI];

    always_comb begin
        case ({wb_adr_i[7:2], 2'b00})
            `VIE_OFS_CTRL: rdata = ctrl_reg;
            `VIE_OFS_GUEST: rdata = guest_reg;
            `VIE_OFS_ENTRY: rdata = entry_reg;
            `VIE_OFS_GIP: rdata = gip_reg;
            `VIE_OFS_HOST: rdata = host_reg;
            `VIE_OFS_MSI: rdata = msi_cfg_reg;
            `VIE_OFS_REASON: rdata = {16'h0000, reason_reg};
            `VIE_OFS_XINFO: rdata = xinfo_reg;
            `VIE_OFS_STATE: rdata = {21'h000000, abcode_reg, 2'b00, guest_ready, shutdown,
                vmx_abort, host_if, st_reg == S_GUEST, st_reg != S_OFF};
            `VIE_OFS_ISTAT: rdata = {27'h0000000, istat_reg};
            `VIE_OFS_IMASK: rdata = {27'h0000000, imask_reg};
            default: rdata = `VIE_RST_WORD;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            wb_dat_o <= `VIE_RST_WORD;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            if (wb_cyc_i && wb_stb_i && !ack_reg) begin
                wb_dat_o <= rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `VIE_RST_WORD;
            gip_reg <= `VIE_RST_WORD;
            host_reg <= `VIE_RST_HOST;
            msi_cfg_reg <= `VIE_RST_WORD;
            imask_reg <= 5'h00;
        end else if (wr_en) begin
            if (hit(wb_adr_i, `VIE_OFS_CTRL)) ctrl_reg <= merge(ctrl_reg, wb_dat_i, wmask);
            if (hit(wb_adr_i, `VIE_OFS_GIP)) gip_reg <= merge(gip_reg, wb_dat_i, wmask);
            if (hit(wb_adr_i, `VIE_OFS_HOST)) host_reg <= merge(host_reg, wb_dat_i, wmask);
            if (hit(wb_adr_i, `VIE_OFS_MSI)) msi_cfg_reg <= merge(msi_cfg_reg, wb_dat_i, wmask);
            if (hit(wb_adr_i, `VIE_OFS_IMASK) && wb_sel_i[0]) imask_reg <= wb_dat_i[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interruptibility and event decode
    assign guest_ready = guest_reg[`VIE_G_IF] && !guest_reg[`VIE_G_STI]
        && !guest_reg[`VIE_G_MOVSS];
    assign exit_irq = ctrl_reg[`VIE_CTRL_EXT] && irq_s;
    assign exit_win = ctrl_reg[`VIE_CTRL_WIN] && guest_ready;
    assign leave_guest = (st_reg == S_GUEST) && (exit_irq || exit_win);
    assign inj = entry_reg[`VIE_INFO_VALID];
    assign inj_ext = inj && entry_reg[`VIE_TYPE_HI:`VIE_TYPE_LO] == `VIE_TYPE_EXT;
    assign ev_fail = (st_reg == S_ROOT) && cmd_resume && inj_ext && !guest_ready;
    assign ev_deliver = (st_reg == S_ROOT) && cmd_resume && inj && !ev_fail && !cmd_leave;
    assign host_bad = !host_reg[0] || (host_reg[31:24] != 8'h00);
    assign fault = msr_store_fail || page_directory_pointer_fail || virtual_machine_control_structure_corrupt || msr_load_fail
        || mc_s || host_bad;
    assign ev_exit = (st_reg == S_EXIT) && !fault;
    assign ev_abort = (st_reg == S_EXIT) && fault;
    assign ev_mce = mc_s && ctrl_reg[`VIE_CTRL_MCE]
        && (((st_reg == S_OFF) && cmd_enter) || ((st_reg == S_ROOT) && cmd_leave));
    assign ev_shut = mc_s && !ctrl_reg[`VIE_CTRL_MCE]
        && (((st_reg == S_OFF) && cmd_enter) || ((st_reg == S_ROOT) && cmd_leave));

    always_comb begin
        if (msr_store_fail) fault_code = `VIE_AB_STORE;
        else if (page_directory_pointer_fail) fault_code = `VIE_AB_PAGE_DIRECTORY_POINTER;
        else if (virtual_machine_control_structure_corrupt) fault_code = `VIE_AB_CORRUPT;
        else if (msr_load_fail) fault_code = `VIE_AB_LOAD;
        else if (mc_s) fault_code = `VIE_AB_MC;
        else if (host_bad) fault_code = `VIE_AB_HOST;
        else fault_code = `VIE_AB_NONE;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            S_OFF: begin
                if (ev_shut) st_next = S_SHUT;
                else if (cmd_enter && !mc_s) st_next = S_ROOT;
            end
            S_ROOT: begin
                if (ev_shut) st_next = S_SHUT;
                else if (cmd_leave && !mc_s) st_next = S_OFF;
                else if (cmd_resume && !ev_fail) st_next = S_GUEST;
            end
            S_GUEST: begin
                if (exit_irq && ctrl_reg[`VIE_CTRL_ACK]) st_next = S_ACK;
                else if (leave_guest) st_next = S_EXIT;
            end
            S_ACK: if (vec_valid) st_next = S_EXIT;
            S_EXIT: st_next = fault ? S_ABORT : S_ROOT;
            S_ABORT: st_next = S_ABORT;
            S_SHUT: st_next = S_SHUT;
            default: st_next = S_OFF;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) st_reg <= S_OFF;
        else st_reg <= st_next;
    end

    assign vmx_abort = st_reg == S_ABORT;
    assign shutdown = st_reg == S_SHUT;

    ////////////////////////////////////////////////////////////////////////////
    // exit reporting and acknowledge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reason_reg <= 16'h0000;
            xinfo_reg <= `VIE_RST_WORD;
            int_ack <= 1'b0;
            abcode_reg <= `VIE_AB_NONE;
        end else begin
            int_ack <= leave_guest && exit_irq && ctrl_reg[`VIE_CTRL_ACK];
            if (leave_guest) begin
                reason_reg <= exit_irq ? `VIE_RSN_EXT : `VIE_RSN_WIN;
                xinfo_reg <= `VIE_RST_WORD;
            end else if (ev_fail) begin
                reason_reg <= `VIE_RSN_FAIL;
            end
            if (st_reg == S_ACK && vec_valid) begin
                xinfo_reg <= {1'b1, 23'h000000, host_vec};
            end
            if (ev_abort) abcode_reg <= fault_code;
        end
    end

    // host flag: cleared by each exit, set again by software
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) host_if <= 1'b0;
        else if (leave_guest || ev_fail) host_if <= 1'b0;
        else if (cmd_setif && st_reg == S_ROOT) host_if <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // guest state and injection
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            guest_reg <= `VIE_RST_WORD;
            entry_reg <= `VIE_RST_WORD;
        end else begin
            if (wr_en && hit(wb_adr_i, `VIE_OFS_GUEST)) begin
                guest_reg <= merge(guest_reg, wb_dat_i, wmask);
            end else if (ev_deliver && inj_ext) begin
                guest_reg[`VIE_G_IF] <= 1'b0;
            end
            if (wr_en && hit(wb_adr_i, `VIE_OFS_ENTRY)) begin
                entry_reg <= merge(entry_reg, wb_dat_i, wmask);
            end else if (ev_deliver) begin
                entry_reg[`VIE_INFO_VALID] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            deliver_valid <= 1'b0;
            deliver_vector <= 8'h00;
            deliver_flags <= `VIE_RST_WORD;
            deliver_ip <= `VIE_RST_WORD;
        end else begin
            deliver_valid <= ev_deliver;
            if (ev_deliver) begin
                deliver_vector <= entry_reg[7:0];
                deliver_flags <= guest_reg;
                deliver_ip <= gip_reg;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) mce_exc <= 1'b0;
        else mce_exc <= ev_mce;
    end

    ////////////////////////////////////////////////////////////////////////////
    // message output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            msi_valid <= 1'b0;
            msi_addr <= `VIE_RST_WORD;
            msi_data <= `VIE_RST_WORD;
        end else if (cmd_msi && !msi_valid) begin
            msi_valid <= 1'b1;
            msi_addr <= msi_bus.addr;
            msi_data <= msi_bus.data;
        end else if (msi_ready) begin
            msi_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: write one to clear, a new event wins
    assign ev_set = {ev_shut, ev_mce, ev_abort, ev_fail, ev_exit};
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            istat_reg <= 5'h00;
        end else if (wr_en && hit(wb_adr_i, `VIE_OFS_ISTAT) && wb_sel_i[0]) begin
            istat_reg <= (istat_reg & ~wb_dat_i[4:0]) | ev_set;
        end else begin
            istat_reg <= istat_reg | ev_set;
        end
    end
    assign irq = |(istat_reg & imask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    chk_ext_exit_go: assert property ((st_reg == S_GUEST) && exit_irq
        |=> (st_reg == (ctrl_reg[`VIE_CTRL_ACK] ? S_ACK : S_EXIT)))
        else $error("guest did not leave on external interrupt");
    chk_if_cleared: assert property (leave_guest |=> !host_if [*2])
        else $error("host flag not cleared on exit");
    chk_reason_ext: assert property (leave_guest && exit_irq
        |=> reason_reg == `VIE_RSN_EXT)
        else $error("exit reason not one");
    chk_ack_vector: assert property ((st_reg == S_ACK) && vec_valid
        |=> xinfo_reg[`VIE_INFO_VALID] && xinfo_reg[7:0] == $past(host_vec))
        else $error("acknowledged vector not stored");
    chk_no_ack: assert property (leave_guest && !ctrl_reg[`VIE_CTRL_ACK]
        |=> !int_ack ##1 (st_reg == S_ROOT || st_reg == S_ABORT))
        else $error("interrupt acknowledged without acknowledge on exit");
    chk_window_exit: assert property ((st_reg == S_GUEST) && exit_win && !exit_irq
        |=> reason_reg == `VIE_RSN_WIN && st_reg == S_EXIT)
        else $error("window exit missing");
    chk_one_event: assert property (deliver_valid
        |-> !entry_reg[`VIE_INFO_VALID] && st_reg == S_GUEST ##1 !deliver_valid)
        else $error("more than one event per entry");
    chk_deliver_data: assert property (ev_deliver
        |=> deliver_valid && deliver_ip == $past(gip_reg)
        && deliver_vector == $past(entry_reg[7:0]))
        else $error("delivered gate data wrong");
    chk_entry_fail: assert property (ev_fail
        |=> reason_reg == `VIE_RSN_FAIL && st_reg == S_ROOT && !deliver_valid)
        else $error("failed entry not reported");
    chk_abort_fault: assert property (ev_abort |=> vmx_abort && abcode_reg != 3'h0)
        else $error("exit fault did not abort");
    chk_mc_instr: assert property (ev_shut |=> shutdown ##1 shutdown)
        else $error("machine check did not shut down");
    chk_mc_exc: assert property (ev_mce |=> mce_exc && !shutdown)
        else $error("machine check exception missing");
endmodule : vie_core

// ---- tb/vie_pic_model.sv ----
// Purpose: interrupt controller facing the exit unit
// Assumes: one clock; vector answered lat cycles after an acknowledge
// Notes: a raised interrupt stays pending until acknowledged or withdrawn
`timescale 1ns/1ns
module vie_pic_model (
    input wire logic ref_clk, // core clock
    input wire logic nrst, // async reset, low
    input wire logic raise, // start an interrupt
    input wire logic clr, // withdraw it
    input wire logic [3:0] lat, // answer delay, at least 1
    input wire vie_pkg::vie_vec_t vec, // vector to return
    input wire logic int_ack, // acknowledge from core
    output logic ext_irq, // interrupt line
    output logic vec_valid, // vector strobe
    output vie_pkg::vie_vec_t host_vec, // vector bus
    output int acks // acknowledges seen
);
    logic [3:0] dly;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ext_irq <= 1'b0;
            vec_valid <= 1'b0;
            host_vec <= 8'h00;
            acks <= 0;
            dly <= 4'h0;
        end else begin
            vec_valid <= 1'b0;
            host_vec <= ~host_vec; // idle bus inverts every cycle, so the last vector is never held steady
            if (raise) ext_irq <= 1'b1;
            if (clr) ext_irq <= 1'b0;
            if (dly != 4'h0) dly <= dly - 4'h1;
            if (int_ack) begin
                acks <= acks + 1;
                dly <= lat;
            end
            if (dly == 4'h1) begin
                vec_valid <= 1'b1;
                host_vec <= vec;
                ext_irq <= 1'b0;
            end
        end
    end
endmodule : vie_pic_model

// ---- tb/vie_core_test.sv ----
// Purpose: self-checking bench of the exit/inject unit
// Assumes: classic wishbone, ack one cycle after the strobe
// Notes: ISTAT bit 0 alone drives irq through IMASK
`timescale 1ns/1ns
`include "vie_defs.svh"
module vie_core_test;
    import vie_pkg::*;
    logic ref_clk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, raise = 0, clr = 0;
    logic msi_ready = 0, wb_ack_o, ext_irq, vec_valid, int_ack, host_if, irq, msi_valid, dv;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] lat = 1;
    logic mc_pin = 0;
    vie_vec_t v = 0, host_vec, dvec;
    vie_word_t wb_dat_i = 0, q, exp, wb_dat_o, msi_addr, msi_data;
    int fails = 0, num_checks = 0, acks, seed = 93008, dv_n = 0, n0;
    always #50 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (dv === 1'b1) dv_n++;
    vie_pic_model u_pic (.ref_clk, .nrst, .raise, .clr, .lat, .vec(v), .int_ack, .ext_irq,
        .vec_valid, .host_vec, .acks);
    vie_core u_dut (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_irq, .mc_pin, .msr_store_fail(1'b0),
        .page_directory_pointer_fail(1'b0), .virtual_machine_control_structure_corrupt(1'b0), .msr_load_fail(1'b0), .vec_valid, .host_vec,
        .int_ack, .host_if, .deliver_valid(dv), .deliver_vector(dvec), .deliver_flags(),
        .deliver_ip(), .mce_exc(), .shutdown(), .vmx_abort(), .irq, .msi_valid, .msi_ready,
        .msi_addr, .msi_data);
    task chk(input string nm, input vie_word_t s, input vie_word_t e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task results;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task bus(input logic w, input logic [7:0] a, input vie_word_t d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge ref_clk);
        while (wb_ack_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                chk("ack", 0, 1);
                results();
            end
            @(posedge ref_clk);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask : bus
    task poll(input int b);
        int n;
        n = 0;
        q = '0;
        while (q[b] !== 1'b1 && n < 40) begin
            bus(1'b0, `VIE_OFS_ISTAT, '0);
            n++;
        end
        chk("istat", q[b], 1'b1);
        if (n >= 40) results();
        chk("irq", irq, b == 0);
        bus(1'b1, `VIE_OFS_ISTAT, 32'h1f);
        chk("irq_clr", irq, 1'b0);
    endtask : poll
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, `VIE_OFS_HOST, '0);
        chk("host", q, `VIE_RST_HOST);
        bus(1'b0, 8'h40, '0);
        chk("unmapped", q, '0);
        bus(1'b1, `VIE_OFS_IMASK, 32'h1);
        bus(1'b1, `VIE_OFS_CMD, 32'h2);
        for (int k = 0; k < 2; k++) begin
            v = $random(seed);
            lat <= k ? 4'h1 : 4'h6;
            bus(1'b1, `VIE_OFS_CTRL, k ? 32'h1 : 32'h3);
            bus(1'b1, `VIE_OFS_GUEST, 32'h1);
            bus(1'b1, `VIE_OFS_CMD, 32'h8);
            chk("host_if_set", host_if, 1'b1);
            bus(1'b1, `VIE_OFS_CMD, 32'h1);
            raise <= 1'b1;
            @(posedge ref_clk);
            raise <= 1'b0;
            poll(0);
            bus(1'b0, `VIE_OFS_REASON, '0);
            chk("reason", q[15:0], `VIE_RSN_EXT);
            chk("host_if", host_if, 1'b0);
            bus(1'b0, `VIE_OFS_XINFO, '0);
            chk("xinfo", q, k ? 32'h0 : {1'b1, 23'h0, v});
            chk("acks", acks, 1);
            chk("pending", ext_irq, k);
            clr <= 1'b1;
            @(posedge ref_clk);
            clr <= 1'b0;
            $display("test exit %0d done", k);
        end
        bus(1'b1, `VIE_OFS_CTRL, '0);
        for (int k = 0; k < 2; k++) begin
            v = $random(seed);
            bus(1'b1, `VIE_OFS_GUEST, k);
            bus(1'b1, `VIE_OFS_ENTRY, {1'b1, 23'h0, v});
            n0 = dv_n;
            bus(1'b1, `VIE_OFS_CMD, 32'h1);
            chk("deliveries", dv_n, n0 + k);
            if (k == 0) begin
                poll(1);
                bus(1'b0, `VIE_OFS_REASON, '0);
                chk("fail_reason", q[15:0], `VIE_RSN_FAIL);
            end else begin
                chk("gate_vector", dvec, v);
                bus(1'b1, `VIE_OFS_GUEST, 32'h1);
                bus(1'b1, `VIE_OFS_CTRL, 32'h4);
                poll(0);
                bus(1'b0, `VIE_OFS_REASON, '0);
                chk("win_reason", q[15:0], `VIE_RSN_WIN);
            end
            $display("test inject %0d done", k);
        end
        mc_pin <= 1'b1;
        exp = $random(seed) & 32'h00ff_87ff;
        bus(1'b1, `VIE_OFS_MSI, exp);
        bus(1'b1, `VIE_OFS_CMD, 32'h10);
        for (int n = 0; n < 20 && msi_valid !== 1'b1; n++) @(posedge ref_clk);
        chk("msi_valid", msi_valid, 1'b1);
        chk("msi_addr", msi_addr, `VIE_MSI_ADDR_BASE | {8'h0, exp[23:16], 16'h0});
        chk("msi_data", msi_data, exp & 32'h0000_87ff);
        msi_ready <= 1'b1;
        @(posedge ref_clk);
        msi_ready <= 1'b0;
        $display("test message done");
        bus(1'b1, `VIE_OFS_CTRL, 32'hc);
        bus(1'b1, `VIE_OFS_CMD, 32'h4);
        poll(3);
        bus(1'b1, `VIE_OFS_CMD, 32'h1);
        poll(2);
        bus(1'b0, `VIE_OFS_STATE, '0);
        chk("state", q[10:0], {`VIE_AB_MC, 8'h29});
        $display("test machine check done");
        results();
    end
endmodule : vie_core_test
